// [shared/dpsc_pkg.sv]
// Purpose: Constants and types for the dual-port SRAM port controller.
// Assumes: 125 MHz clock; one port of an asynchronous dual-port SRAM.
// Notes:   Timing figures in ns, cycle counts derived from the clock rate.
package dpsc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 8;
  // -----------------------------------------------------------------
  // Timing (slowest speed grade)
  // -----------------------------------------------------------------
  localparam int unsigned T_WP_NS   = 12;
  localparam int unsigned T_WZ_NS   = 4;
  localparam int unsigned T_DW_NS   = 10;
  localparam int unsigned T_HZ_NS   = 8;
  localparam int unsigned T_SAA_NS  = 20;
  localparam int unsigned T_AA_NS   = 15;
  localparam int unsigned T_SWRD_NS = 5;
  localparam int unsigned T_WC_NS   = 15;

  function automatic int unsigned cyc_up(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned WP_CYC   = cyc_up(T_WP_NS);
  localparam int unsigned WPOE_CYC = cyc_up(T_WZ_NS + T_DW_NS);
  localparam int unsigned HZ_CYC   = cyc_up(T_HZ_NS);
  localparam int unsigned RD_CYC   = cyc_up(T_AA_NS);
  localparam int unsigned SRD_CYC  = cyc_up(T_SAA_NS);
  localparam int unsigned SWRD_CYC = cyc_up(T_SWRD_NS);
  localparam int unsigned WC_CYC   = cyc_up(T_WC_NS);
  localparam int unsigned DW_CYC   = cyc_up(T_DW_NS);
  // Data enable trails the write strobe by one cycle
  localparam int unsigned DLAG_CYC = 1;
  // Pin register lag plus three synchroniser flops
  localparam int unsigned SYNC_CYC = 4;
  localparam int unsigned CNT_W    = 4;

  localparam int unsigned DATA_W = 36;
  localparam int unsigned ADDR_W = 17;
  localparam int unsigned BE_W   = 4;
  localparam int unsigned SEM_AW = 3;

  typedef enum logic [1:0] {
    DPSC_OP_READ,
    DPSC_OP_WRITE,
    DPSC_OP_SEM_WRITE,
    DPSC_OP_SEM_READ
  } dpsc_op_t;

endpackage

// [shared/dpsc_pins_if.sv]
// Purpose: Pin-level signals from sequencer to pin driver.
// Assumes: All signals on clk; strobes active low.
// Notes:   Data output enable gated by the pin driver.
`timescale 1ns/100ps
interface dpsc_pins_if;
  logic                          cs_n;
  logic                          rw_n;
  logic                          oe_n;
  logic                          semaphore_select_n;
  logic [dpsc_pkg::BE_W-1:0]     byte_lane_enable_n;
  logic [dpsc_pkg::ADDR_W-1:0]   addr;
  logic [dpsc_pkg::DATA_W-1:0]   dout;
  logic                          dout_en;
  modport seq (output cs_n, rw_n, oe_n, semaphore_select_n,
               byte_lane_enable_n, addr, dout, dout_en);
  modport drv (input cs_n, rw_n, oe_n, semaphore_select_n,
               byte_lane_enable_n, addr, dout, dout_en);
endinterface

// [design/dpsc_pin_drv.sv]
// Purpose: Registered pin outputs of the controller.
// Assumes: Sequencer values are already glitch free per cycle.
// Notes:   All outputs are flip-flops so pins change on clock edges only.
`timescale 1ns/100ps
module dpsc_pin_drv (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  dpsc_pins_if.drv                         p,
  output logic                             cs_n,
  output logic                             rw_n,
  output logic                             oe_n,
  output logic                             semaphore_select_n,
  output logic [dpsc_pkg::BE_W-1:0]        byte_lane_enable_n,
  output logic [dpsc_pkg::ADDR_W-1:0]      addr,
  output logic [dpsc_pkg::DATA_W-1:0]      data_o,
  output logic                             data_oe
);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_n               <= 1'b1;
      rw_n               <= 1'b1;
      oe_n               <= 1'b1;
      semaphore_select_n <= 1'b1;
      byte_lane_enable_n <= '1;
      addr               <= '0;
      data_o             <= '0;
      data_oe            <= 1'b0;
    end else begin
      cs_n               <= p.cs_n;
      rw_n               <= p.rw_n;
      oe_n               <= p.oe_n;
      semaphore_select_n <= p.semaphore_select_n;
      byte_lane_enable_n <= p.byte_lane_enable_n;
      addr               <= p.addr;
      data_o             <= p.dout;
      // Never drive while device may drive
      data_oe            <= p.dout_en & ~p.rw_n;
    end
  end
endmodule

// [design/dpsc_port_ctrl.sv]
// Purpose: Host-side controller for one port of an async dual-port SRAM.
// Assumes: Requests come from logic on clk; data pins from another domain.
// Notes:   One access at a time; semaphore flag read from data bit 0.
`timescale 1ns/100ps
module dpsc_port_ctrl #(
  parameter int unsigned DATA_W = dpsc_pkg::DATA_W,
  parameter int unsigned ADDR_W = dpsc_pkg::ADDR_W,
  parameter int unsigned BE_W   = dpsc_pkg::BE_W
) (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   req_valid,
  output logic                        req_ready,
  input  wire dpsc_pkg::dpsc_op_t     req_op,
  input  wire logic [ADDR_W-1:0]      req_addr,
  input  wire logic [DATA_W-1:0]      req_wdata,
  input  wire logic [BE_W-1:0]        req_be,
  input  wire logic                   req_oe_low,
  output logic                        rsp_valid,
  output logic [DATA_W-1:0]           rsp_rdata,
  output logic                        rsp_sem_flag,
  output logic                        rsp_sem_err,
  output logic                        cs_n,
  output logic                        rw_n,
  output logic                        oe_n,
  output logic                        semaphore_select_n,
  output logic [BE_W-1:0]             byte_lane_enable_n,
  output logic [ADDR_W-1:0]           addr,
  input  wire logic [DATA_W-1:0]      data_i,
  output logic [DATA_W-1:0]           data_o,
  output logic                        data_oe
);
  localparam int unsigned CW = dpsc_pkg::CNT_W;
  // Data only starts a cycle into the pulse, so setup time sets the floor
  localparam int unsigned PW_MIN   = dpsc_pkg::DW_CYC + dpsc_pkg::DLAG_CYC;
  localparam int unsigned PW_CYC   = (dpsc_pkg::WP_CYC > PW_MIN) ?
                                     dpsc_pkg::WP_CYC : PW_MIN;
  localparam int unsigned PWOE_CYC = (dpsc_pkg::WPOE_CYC > PW_MIN) ?
                                     dpsc_pkg::WPOE_CYC : PW_MIN;

  // -----------------------------------------------------------------
  // Data pin synchroniser
  // -----------------------------------------------------------------
  logic [DATA_W-1:0] s1_q, s2_q, s3_q, din_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      din_q <= '0;
    end else begin
      s1_q <= data_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < DATA_W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          din_q[i] <= s2_q[i];
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    DPSC_IDLE, DPSC_SETUP, DPSC_PULSE, DPSC_RECOV, DPSC_READ, DPSC_SAMPLE
  } dpsc_state_t;

  dpsc_state_t        st_q;
  logic [CW-1:0]      cnt_q;
  dpsc_pkg::dpsc_op_t op_q;
  logic [ADDR_W-1:0]  addr_q;
  logic [DATA_W-1:0]  wdata_q;
  logic [BE_W-1:0]    be_q;
  logic               oe_low_q;
  logic               cs_n_q, rw_n_q, oe_n_q, sem_n_q, den_q;
  logic [BE_W-1:0]    be_n_q;
  logic               is_sem, is_wr;

  assign is_sem    = (op_q == dpsc_pkg::DPSC_OP_SEM_WRITE) ||
                     (op_q == dpsc_pkg::DPSC_OP_SEM_READ);
  assign is_wr     = (op_q == dpsc_pkg::DPSC_OP_WRITE) ||
                     (op_q == dpsc_pkg::DPSC_OP_SEM_WRITE);
  assign req_ready = (st_q == DPSC_IDLE);

  function automatic logic [CW-1:0] cyc(input int unsigned n);
    return CW'(n - 1);
  endfunction

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q     <= DPSC_IDLE;
      cnt_q    <= '0;
      op_q     <= dpsc_pkg::DPSC_OP_READ;
      addr_q   <= '0;
      wdata_q  <= '0;
      be_q     <= '0;
      oe_low_q <= 1'b0;
      cs_n_q   <= 1'b1;
      rw_n_q   <= 1'b1;
      oe_n_q   <= 1'b1;
      sem_n_q  <= 1'b1;
      be_n_q   <= '1;
      den_q    <= 1'b0;
    end else begin
      case (st_q)
        DPSC_IDLE: begin
          if (req_valid) begin
            // Address only changes here, all strobes high
            op_q     <= req_op;
            addr_q   <= req_addr;
            wdata_q  <= req_wdata;
            be_q     <= req_be;
            oe_low_q <= req_oe_low;
            st_q     <= DPSC_SETUP;
          end
        end
        DPSC_SETUP: begin
          // Strobe and selects go low on the same edge: on a write the device keeps outputs off, on a read OE low turns them on
          be_n_q <= ~be_q;
          if (is_wr) begin
            rw_n_q <= 1'b0;
            oe_n_q <= ~oe_low_q;
            st_q   <= DPSC_PULSE;
            // Output drivers need turn-off time before data setup
            cnt_q  <= oe_low_q ? cyc(PWOE_CYC)
                               : cyc(PW_CYC);
          end else begin
            oe_n_q <= 1'b0;
            st_q   <= DPSC_READ;
            cnt_q  <= is_sem ? cyc(dpsc_pkg::SRD_CYC)
                             : cyc(dpsc_pkg::RD_CYC);
          end
          // Exactly one of the two selects is low
          cs_n_q  <= is_sem;
          sem_n_q <= ~is_sem;
        end
        DPSC_PULSE: begin
          // Data driven only once strobe is low (device outputs off)
          den_q <= 1'b1;
          if (cnt_q == '0) begin
            rw_n_q  <= 1'b1;
            cs_n_q  <= 1'b1;
            sem_n_q <= 1'b1;
            be_n_q  <= '1;
            oe_n_q  <= 1'b1;
            st_q    <= DPSC_RECOV;
            cnt_q   <= is_sem ? cyc(dpsc_pkg::SWRD_CYC)
                              : cyc(dpsc_pkg::HZ_CYC);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        DPSC_READ: begin
          if (cnt_q == '0) begin
            st_q  <= DPSC_SAMPLE;
            cnt_q <= CW'(dpsc_pkg::SYNC_CYC);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        DPSC_SAMPLE: begin
          // Wait for the synchroniser to settle, then release
          if (cnt_q == '0) begin
            cs_n_q  <= 1'b1;
            sem_n_q <= 1'b1;
            be_n_q  <= '1;
            oe_n_q  <= 1'b1;
            st_q    <= DPSC_RECOV;
            cnt_q   <= cyc(dpsc_pkg::HZ_CYC);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        DPSC_RECOV: begin
          den_q <= 1'b0;
          if (cnt_q == '0) begin
            st_q <= DPSC_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: st_q <= DPSC_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Response
  // -----------------------------------------------------------------
  logic done;
  assign done = (st_q == DPSC_SAMPLE) && (cnt_q == '0);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rsp_valid    <= 1'b0;
      rsp_rdata    <= '0;
      rsp_sem_flag <= 1'b0;
      rsp_sem_err  <= 1'b0;
    end else begin
      rsp_valid <= done ||
                   ((st_q == DPSC_PULSE) && (cnt_q == '0));
      if (done) begin
        rsp_rdata    <= din_q;
        // Flag value replicated on every line
        rsp_sem_flag <= din_q[0];
        rsp_sem_err  <= is_sem && (din_q != {DATA_W{din_q[0]}});
      end
    end
  end

  dpsc_pins_if pins ();
  assign pins.cs_n               = cs_n_q;
  assign pins.rw_n               = rw_n_q;
  assign pins.oe_n               = oe_n_q;
  assign pins.semaphore_select_n = sem_n_q;
  assign pins.byte_lane_enable_n = be_n_q;
  assign pins.addr               = addr_q;
  assign pins.dout               = wdata_q;
  assign pins.dout_en            = den_q;

  dpsc_pin_drv u_drv (
    .clk                (clk),
    .rstn               (rstn),
    .p                  (pins),
    .cs_n               (cs_n),
    .rw_n               (rw_n),
    .oe_n               (oe_n),
    .semaphore_select_n (semaphore_select_n),
    .byte_lane_enable_n (byte_lane_enable_n),
    .addr               (addr),
    .data_o             (data_o),
    .data_oe            (data_oe)
  );
endmodule

// [verification/dpsc_monitor.sv]
// Purpose: Pin protocol checks on the port controller.
// Assumes: Pins are registered on clk.
// Notes:   Host-side pin rules only.
`timescale 1ns/100ps
module dpsc_monitor (
  input wire logic                      clk,
  input wire logic                      rstn,
  input wire logic                      cs_n,
  input wire logic                      rw_n,
  input wire logic                      semaphore_select_n,
  input wire logic [dpsc_pkg::BE_W-1:0] byte_lane_enable_n,
  input wire logic [dpsc_pkg::ADDR_W-1:0] addr,
  input wire logic                      data_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_wr_go; $fell(rw_n); endsequence
  sequence s_wr_end; $rose(rw_n); endsequence
  property p_addr_quiet;
    !$stable(addr) |-> $past(rw_n) || $past(cs_n && semaphore_select_n)
      || $past(&byte_lane_enable_n);
  endproperty
  a_addr_quiet: assert property (p_addr_quiet)
    else $error("address moved during an active write");
  property p_sel_excl; cs_n || semaphore_select_n; endproperty
  a_sel_excl: assert property (p_sel_excl)
    else $error("array and semaphore selected together");
  property p_sel_hold;
    !rw_n && $past(!rw_n) |-> $stable(cs_n) && $stable(semaphore_select_n);
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("select changed inside a write pulse");
  property p_sem_cs; !semaphore_select_n && !rw_n |=> cs_n [*3]; endproperty
  a_sem_cs: assert property (p_sem_cs)
    else $error("chip select low around a semaphore access");
  property p_wp; s_wr_go |-> !rw_n [*2]; endproperty
  a_wp: assert property (p_wp)
    else $error("write pulse shorter than two cycles");
  property p_data_end; s_wr_end |-> $past(data_oe, 1) && $past(data_oe, 2);
  endproperty
  a_data_end: assert property (p_data_end)
    else $error("write data not set up before end of write");
  property p_drv; data_oe |-> !rw_n || $past(!rw_n); endproperty
  a_drv: assert property (p_drv)
    else $error("data driven outside a write");
  property p_drv_start; $rose(data_oe) |-> $past(!rw_n); endproperty
  a_drv_start: assert property (p_drv_start)
    else $error("data driven before outputs released");
endmodule

bind dpsc_port_ctrl dpsc_monitor dpsc_monitor_inst (.clk, .rstn, .cs_n,
  .rw_n, .semaphore_select_n, .byte_lane_enable_n, .addr, .data_oe);

// [verification/dpsc_sram_model.sv]
// Purpose: One port of the dual-port SRAM with semaphore flags.
// Assumes: Pins change only on clk edges.
// Notes:   Released bus toggles, since it has no pull.
`timescale 1ns/100ps
module dpsc_sram_model (
  input wire logic        clk,
  input wire logic        slow,
  input wire logic [7:0]  other_holds,
  input wire logic        cs_n,
  input wire logic        rw_n,
  input wire logic        oe_n,
  input wire logic        semaphore_select_n,
  input wire logic [3:0]  byte_lane_enable_n,
  input wire logic [16:0] addr,
  input wire logic [35:0] data_o,
  input wire logic        data_oe,
  output logic [35:0]     data_i,
  output logic            clash
);
  logic [35:0] mem [int];
  logic [35:0] drv_d, drv_q, last_q, wd_q;
  logic [16:0] wa_q;
  logic [3:0]  wb_q;
  logic [7:0]  sem_q;
  logic        den, den_q, wr_q, sw_q, wact, sact;
  initial begin
    {last_q, sem_q, clash, den_q, wr_q, sw_q} = {36'h0, 8'hff, 4'h0};
  end
  assign wact = !cs_n && !rw_n && semaphore_select_n;
  assign sact = cs_n && !semaphore_select_n && !rw_n;
  assign den = !oe_n && rw_n && (cs_n != semaphore_select_n);
  always_comb begin
    drv_d = mem.exists(addr) ? mem[addr] : 36'h0;
    if (!semaphore_select_n)
      drv_d = {36{sem_q[addr[2:0]]}};
  end
  // Slow grade turns on late but releases promptly
  always @(den or drv_d) begin
    den_q <= #((den && slow) ? 14 : 2) den;
    drv_q <= #(slow ? 14 : 2) drv_d;
  end
  assign data_i = data_oe ? data_o : den_q ? drv_q : ~last_q;
  always @(posedge clk) begin
    last_q <= data_i;
    wr_q <= wact;
    sw_q <= sact;
    if (data_oe && den_q)
      clash <= 1'b1;
    if (wact || sact) begin
      {wa_q, wd_q, wb_q} <= {addr, data_i, byte_lane_enable_n};
    end
    if (wr_q && !wact) begin
      if (!mem.exists(wa_q))
        mem[wa_q] = 36'h0;
      for (int i = 0; i < 4; i++)
        if (!wb_q[i])
          mem[wa_q][i*9+:9] = wd_q[i*9+:9];
    end
    if (sw_q && !sact)
      sem_q[wa_q[2:0]] <= wd_q[0] | other_holds[wa_q[2:0]];
  end
endmodule

// [verification/tb_dpsc_port_ctrl.sv]
// Purpose: Self-checking bench for the port controller.
// Assumes: SRAM model answers on the pin side.
// Notes:   Every test is one task; run ends in summarize.
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  fails++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_dpsc_port_ctrl;
  logic        clk, rstn, req_valid, req_ready, req_oe_low, rsp_valid;
  logic        rsp_sem_flag, rsp_sem_err, cs_n, rw_n, oe_n, data_oe;
  logic        semaphore_select_n, slow, clash;
  logic [16:0] req_addr, addr;
  logic [35:0] req_wdata, rsp_rdata, data_i, data_o, rd;
  logic [3:0]  req_be, byte_lane_enable_n;
  logic [7:0]  other_holds;
  int          tests_run, fails;
  dpsc_pkg::dpsc_op_t req_op;
  dpsc_port_ctrl dpsc_port_ctrl_inst (.clk, .rstn, .req_valid, .req_ready,
    .req_op, .req_addr, .req_wdata, .req_be, .req_oe_low, .rsp_valid,
    .rsp_rdata, .rsp_sem_flag, .rsp_sem_err, .cs_n, .rw_n, .oe_n,
    .semaphore_select_n, .byte_lane_enable_n, .addr, .data_i, .data_o,
    .data_oe);
  dpsc_sram_model dpsc_sram_model_inst (.clk, .slow, .other_holds, .cs_n,
    .rw_n, .oe_n, .semaphore_select_n, .byte_lane_enable_n, .addr, .data_o,
    .data_oe, .data_i, .clash);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic op(input dpsc_pkg::dpsc_op_t o, input logic [16:0] a,
                    input logic [35:0] w, input logic [3:0] be);
    int n = 0;
    @(posedge clk);
    {req_valid, req_op, req_addr, req_wdata, req_be} <= {1'b1, o, a, w, be};
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    while (rsp_valid !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    rd = rsp_rdata;
    `CHK("rsp_valid", 1'b1, rsp_valid)
  endtask
  task automatic t_array;
    // Full word, then two lanes with OE held low, then slow read-back
    op(dpsc_pkg::DPSC_OP_WRITE, 17'h1ffff, 36'h9_1234_5678, 4'hf);
    req_oe_low <= 1'b1;
    op(dpsc_pkg::DPSC_OP_WRITE, 17'h1ffff, 36'h0_abcd_ef01, 4'h5);
    {req_oe_low, slow} <= 2'b01;
    op(dpsc_pkg::DPSC_OP_READ, 17'h1ffff, 36'h0, 4'hf);
    `CHK("array", 36'h9_13cc_5701, rd)
    slow <= 1'b0;
    op(dpsc_pkg::DPSC_OP_WRITE, 17'h00000, 36'h5_a5a5_a5a5, 4'hf);
    op(dpsc_pkg::DPSC_OP_READ, 17'h00000, 36'h0, 4'hf);
    `CHK("array0", 36'h5_a5a5_a5a5, rd)
    $display("test array done");
  endtask
  task automatic t_sem;
    other_holds <= 8'h5a;
    for (int i = 0; i < 8; i++) begin
      op(dpsc_pkg::DPSC_OP_SEM_WRITE, 17'(i), 36'h0, 4'hf);
      op(dpsc_pkg::DPSC_OP_SEM_READ, 17'(i), 36'h0, 4'hf);
      `CHK("sem_word", {36{other_holds[i]}}, rd)
      `CHK("sem_err", 1'b0, rsp_sem_err)
      op(dpsc_pkg::DPSC_OP_SEM_WRITE, 17'(i), 36'hf_ffff_ffff, 4'hf);
      op(dpsc_pkg::DPSC_OP_SEM_READ, 17'(i), 36'h0, 4'hf);
      `CHK("sem_free", 1'b1, rsp_sem_flag)
    end
    $display("test semaphore done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {rstn, req_valid, req_oe_low, slow, other_holds} = 12'h0;
    {req_addr, req_wdata, req_be} = 57'h0;
    req_op = dpsc_pkg::DPSC_OP_READ;
    repeat (16) @(posedge clk);
    `CHK("reset", 5'h1f, {cs_n, rw_n, oe_n, semaphore_select_n, req_ready})
    rstn <= 1'b1;
    t_array();
    t_sem();
    `CHK("clash", 1'b0, clash)
    summarize();
  end
  initial begin
    #100000;
    fails++;
    $display("[ERR] watchdog expired");
    summarize();
  end
endmodule
